/* File: shared/uart_fc_pkg.sv */
package uart_fc_pkg;
  // Register offsets on the 8-bit host bus
  localparam logic [2:0] OFS_DIV_LOW = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
  localparam logic [2:0] OFS_QUEUE_CTRL = 3'h2;
  localparam logic [2:0] OFS_INT_IDENT = 3'h2;
  localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
  // Queue control fields
  localparam int QC_TRIG_MSB = 7;
  localparam int QC_TRIG_LSB = 6;
  localparam int QC_UNUSED_BIT = 3;
  localparam int QC_TX_FLUSH_BIT = 2;
  localparam int QC_RX_FLUSH_BIT = 1;
  localparam int QC_ENABLE_BIT = 0;
  // Line control fields
  localparam int LC_DIV_SEL_BIT = 7;
  localparam int LC_BREAK_BIT = 6;
  // Interrupt enable: received data available
  localparam int IE_RX_AVAIL_BIT = 0;
  // Reset values
  localparam logic [7:0] QUEUE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  // Receive trigger thresholds in bytes
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;
  // Identification codes
  localparam logic [3:0] IDENT_NONE = 4'h1;
  localparam logic [3:0] IDENT_RX_AVAIL = 4'h4;
  localparam logic [1:0] FIFO_STATUS_ON = 2'h3;
  // Queue geometry
  localparam int QUEUE_WIDTH = 8;
  localparam int QUEUE_DEPTH = 8;
  localparam int QUEUE_CNT_W = 4;

  typedef struct packed {
    logic [1:0] rx_trigger_level;
    logic fifo_mode_enable;
  } queue_cfg_t;

  typedef struct packed {
    logic divisor_latch_select;
    logic break_force;
  } line_cfg_t;

  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_RUN = 2'b01,
    FL_DONE = 2'b11
  } flush_state_t;
endpackage

/* File: hw/byte_queue.sv */
module byte_queue
  import uart_fc_pkg::*;
#(
  parameter int WIDTH = QUEUE_WIDTH,
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int CW = QUEUE_CNT_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] next_count;
  logic push, pop;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    // Flush clears both pointers and the counter; data words stay but become unreachable
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end else begin
      if (push) next_wr_ptr = AW'(wr_ptr + 1'b1);
      if (pop) next_rd_ptr = AW'(rd_ptr + 1'b1);
      next_count = CW'(count + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_data <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      // Word written this edge is not yet in mem, so bypass it when it becomes the head
      out_data <= (push && !flush && next_rd_ptr == wr_ptr) ? in_data : mem[next_rd_ptr];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push && !flush) mem[wr_ptr] <= in_data;
  end
endmodule // byte_queue

/* File: hw/uart_fifo_line_ctrl.sv */
module uart_fifo_line_ctrl
  import uart_fc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic test_mode,
  input wire logic baud_clock_out,
  input wire logic tx_shift_serial,
  input wire logic transmitter_empty,
  output logic serial_out,
  output logic [15:0] divisor,
  output logic tx_byte_valid,
  input wire logic tx_byte_ready,
  output logic [7:0] tx_byte,
  input wire logic rx_byte_valid,
  output logic rx_byte_ready,
  input wire logic [7:0] rx_byte,
  output logic fifo_mode,
  output logic rx_data_irq
);
  queue_cfg_t qcfg, next_qcfg;
  line_cfg_t lcfg;
  logic [7:0] line_format_control, next_line_format_control;
  logic [7:0] int_enable_reg, next_int_enable_reg;
  logic [15:0] next_divisor;
  logic tx_flush_req, rx_flush_req, next_tx_flush_req, next_rx_flush_req;
  flush_state_t fl_state, next_fl_state;
  logic tx_flush, rx_flush, mode_clear;
  logic [3:0] tx_count, rx_count;
  logic [7:0] rx_out;
  logic rx_valid, rx_pop, tx_push, tx_in_ready;
  logic [4:0] trig_bytes;
  logic [7:0] ident;

  function automatic logic acc(input logic [2:0] a, input logic [2:0] ofs, input logic sel, input logic want);
    acc = (a == ofs) && (sel == want);
  endfunction

  assign lcfg = line_cfg_t'(line_format_control[LC_DIV_SEL_BIT:LC_BREAK_BIT]);
  assign fifo_mode = qcfg.fifo_mode_enable;

  always_comb begin
    next_qcfg = qcfg;
    next_line_format_control = line_format_control;
    next_int_enable_reg = int_enable_reg;
    next_divisor = divisor;
    // Flush requests return to zero once done; a new request in that cycle still wins
    next_tx_flush_req = (fl_state == FL_DONE) ? 1'b0 : tx_flush_req;
    next_rx_flush_req = (fl_state == FL_DONE) ? 1'b0 : rx_flush_req;
    mode_clear = 1'b0;
    tx_push = 1'b0;
    if (wr_en) begin
      case (addr)
        OFS_QUEUE_CTRL: begin
          if (!wr_data[QC_ENABLE_BIT] || qcfg.fifo_mode_enable != wr_data[QC_ENABLE_BIT]) mode_clear = 1'b1;
          next_qcfg.fifo_mode_enable = wr_data[QC_ENABLE_BIT];
          if (wr_data[QC_ENABLE_BIT]) begin
            next_qcfg.rx_trigger_level = wr_data[QC_TRIG_MSB:QC_TRIG_LSB];
            next_tx_flush_req = next_tx_flush_req | wr_data[QC_TX_FLUSH_BIT];
            next_rx_flush_req = next_rx_flush_req | wr_data[QC_RX_FLUSH_BIT];
          end
        end
        OFS_LINE_CTRL: next_line_format_control = wr_data;
        default: begin
          if (acc(addr, OFS_DIV_LOW, lcfg.divisor_latch_select, 1'b1)) next_divisor[7:0] = wr_data;
          if (acc(addr, OFS_DIV_HIGH, lcfg.divisor_latch_select, 1'b1)) next_divisor[15:8] = wr_data;
          if (acc(addr, OFS_INT_ENABLE, lcfg.divisor_latch_select, 1'b0)) next_int_enable_reg = wr_data;
          if (acc(addr, OFS_DATA, lcfg.divisor_latch_select, 1'b0)) tx_push = 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    next_fl_state = fl_state;
    case (fl_state)
      FL_IDLE: if (tx_flush_req || rx_flush_req) next_fl_state = FL_RUN;
      FL_RUN: next_fl_state = FL_DONE;
      FL_DONE: next_fl_state = FL_IDLE;
      default: next_fl_state = FL_IDLE;
    endcase
  end

  assign tx_flush = mode_clear || (fl_state == FL_RUN && tx_flush_req);
  assign rx_flush = mode_clear || (fl_state == FL_RUN && rx_flush_req);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      qcfg <= queue_cfg_t'(QUEUE_CONTROL_RESET[2:0]);
      line_format_control <= LINE_CONTROL_RESET;
      int_enable_reg <= INT_ENABLE_RESET;
      divisor <= DIVISOR_RESET;
      tx_flush_req <= 1'b0;
      rx_flush_req <= 1'b0;
      fl_state <= FL_IDLE;
    end else begin
      qcfg <= next_qcfg;
      line_format_control <= next_line_format_control;
      int_enable_reg <= next_int_enable_reg;
      divisor <= next_divisor;
      tx_flush_req <= next_tx_flush_req;
      rx_flush_req <= next_rx_flush_req;
      fl_state <= next_fl_state;
    end
  end

  // Non-FIFO mode keeps a single holding slot, so depth collapses to one word
  logic tx_in_valid, rx_in_ready_q;
  assign tx_in_valid = tx_push && (qcfg.fifo_mode_enable || tx_count == 4'h0);
  assign rx_byte_ready = rx_in_ready_q && (qcfg.fifo_mode_enable || rx_count == 4'h0);

  byte_queue #(.WIDTH(QUEUE_WIDTH), .DEPTH(QUEUE_DEPTH), .CW(QUEUE_CNT_W)) tx_queue (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(tx_flush),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(wr_data),
    .out_valid(tx_byte_valid),
    .out_ready(tx_byte_ready),
    .out_data(tx_byte),
    .count(tx_count)
  );

  byte_queue #(.WIDTH(QUEUE_WIDTH), .DEPTH(QUEUE_DEPTH), .CW(QUEUE_CNT_W)) rx_queue (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(rx_flush),
    .in_valid(rx_byte_valid),
    .in_ready(rx_in_ready_q),
    .in_data(rx_byte),
    .out_valid(rx_valid),
    .out_ready(rx_pop),
    .out_data(rx_out),
    .count(rx_count)
  );

  assign rx_pop = rd_en && acc(addr, OFS_DATA, lcfg.divisor_latch_select, 1'b0);

  always_comb begin
    case (qcfg.rx_trigger_level)
      2'b00: trig_bytes = TRIG_1;
      2'b01: trig_bytes = TRIG_4;
      2'b10: trig_bytes = TRIG_8;
      default: trig_bytes = TRIG_14;
    endcase
  end

  // Threshold interrupt
  // Eight-word queue cannot reach 14, so that level caps at full
  assign rx_data_irq = int_enable_reg[IE_RX_AVAIL_BIT] && rx_valid &&
    (!qcfg.fifo_mode_enable || {1'b0, rx_count} >= trig_bytes ||
     (trig_bytes > 5'(QUEUE_DEPTH) && rx_count == 4'(QUEUE_DEPTH)));

  always_comb begin
    ident = {(qcfg.fifo_mode_enable ? FIFO_STATUS_ON : 2'h0), 2'h0, (rx_data_irq ? IDENT_RX_AVAIL : IDENT_NONE)};
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      case (addr)
        OFS_INT_IDENT: rd_data <= ident;
        OFS_LINE_CTRL: rd_data <= line_format_control;
        OFS_DIV_HIGH: rd_data <= lcfg.divisor_latch_select ? divisor[15:8] : int_enable_reg;
        OFS_DIV_LOW: rd_data <= lcfg.divisor_latch_select ? divisor[7:0] : rx_out;
        default: rd_data <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      serial_out <= 1'b1;
    end else if (lcfg.break_force) begin
      serial_out <= 1'b0;
    end else if (test_mode) begin
      serial_out <= lcfg.divisor_latch_select ? baud_clock_out : 1'b1;
    end else begin
      serial_out <= tx_shift_serial;
    end
  end
endmodule // uart_fifo_line_ctrl

/* File: tb/uart_fc_checker.sv */
module uart_fc_checker
  import uart_fc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic test_mode,
  input wire logic baud_clock_out,
  input wire logic serial_out,
  input wire logic [15:0] divisor,
  input wire logic tx_byte_valid,
  input wire logic fifo_mode,
  input wire logic rx_data_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lc;
  logic [7:0] next_lc;
  // Line control copy, rebuilt from the bus
  always_comb next_lc = !rst_n ? LINE_CONTROL_RESET : (wr_en && addr == OFS_LINE_CTRL) ? wr_data : lc;
  always_ff @(posedge ref_clk) lc <= next_lc;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_qc_wr;
    wr_en && addr == OFS_QUEUE_CTRL;
  endsequence
  sequence s_dl_wr;
    wr_en && lc[LC_DIV_SEL_BIT];
  endsequence
  property p_break; lc[LC_BREAK_BIT] && !test_mode |=> !serial_out; endproperty
  a_break: assert property (p_break) else $error("line not spacing");
  property p_tm; lc[LC_DIV_SEL_BIT] && !lc[LC_BREAK_BIT] && test_mode |=> serial_out == $past(baud_clock_out); endproperty
  a_tm: assert property (p_tm) else $error("baud clock not on line");
  property p_dl_lo; s_dl_wr ##0 (addr == OFS_DIV_LOW) |=> divisor[7:0] == $past(wr_data); endproperty
  a_dl_lo: assert property (p_dl_lo) else $error("divisor low");
  property p_dl_hi; s_dl_wr ##0 (addr == OFS_DIV_HIGH) |=> divisor[15:8] == $past(wr_data); endproperty
  a_dl_hi: assert property (p_dl_hi) else $error("divisor high");
  property p_dl_keep; wr_en && !lc[LC_DIV_SEL_BIT] |=> $stable(divisor); endproperty
  a_dl_keep: assert property (p_dl_keep) else $error("divisor changed");
  property p_mode; s_qc_wr |=> fifo_mode == $past(wr_data[QC_ENABLE_BIT]); endproperty
  a_mode: assert property (p_mode) else $error("queue mode");
  property p_txf; s_qc_wr ##0 (wr_data[QC_TX_FLUSH_BIT] && wr_data[QC_ENABLE_BIT]) |-> ##[1:4] !tx_byte_valid; endproperty
  a_txf: assert property (p_txf) else $error("tx queue kept");
  property p_rxf; s_qc_wr ##0 (wr_data[QC_RX_FLUSH_BIT] && wr_data[QC_ENABLE_BIT]) |-> ##[1:4] !rx_data_irq; endproperty
  a_rxf: assert property (p_rxf) else $error("rx queue kept");
endmodule // uart_fc_checker

bind uart_fifo_line_ctrl uart_fc_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
  .wr_data(wr_data), .test_mode(test_mode), .baud_clock_out(baud_clock_out), .serial_out(serial_out),
  .divisor(divisor), .tx_byte_valid(tx_byte_valid), .fifo_mode(fifo_mode), .rx_data_irq(rx_data_irq));

/* File: tb/serial_far_end.sv */
module serial_far_end (
  input wire logic ref_clk,
  input wire logic stall,
  input wire logic tx_byte_valid,
  output logic tx_byte_ready,
  input wire logic [7:0] tx_byte,
  output logic rx_byte_valid,
  input wire logic rx_byte_ready,
  output logic [7:0] rx_byte,
  output logic baud_clock_out,
  output logic tx_shift_serial,
  output logic transmitter_empty
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    baud_clock_out = 1'b0;
  end
  // Mark level between characters
  assign tx_shift_serial = 1'b1;
  assign transmitter_empty = !tx_byte_valid;
  assign tx_byte_ready = !stall;
  always @(negedge ref_clk) baud_clock_out <= !baud_clock_out;
  always @(posedge ref_clk) begin
    if (tx_byte_valid && tx_byte_ready)
      got.push_back(tx_byte);
  end
  // Old data is inverted so a late read cannot match
  task automatic push(input logic [7:0] b);
    @(negedge ref_clk);
    rx_byte_valid = 1'b1;
    rx_byte = b;
    #1;
    while (rx_byte_ready !== 1'b1) begin
      @(negedge ref_clk);
      #1;
    end
    @(negedge ref_clk);
    rx_byte_valid = 1'b0;
    rx_byte = ~b;
  endtask
endmodule // serial_far_end

/* File: tb/test_uart_fifo_and_line_control.sv */
module test_uart_fifo_and_line_control
  import uart_fc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, test_mode = 1'b0, stall = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00, rd_data, tx_byte, rx_byte;
  logic [15:0] divisor;
  logic baud_clock_out, tx_shift_serial, transmitter_empty, serial_out, tx_byte_valid, tx_byte_ready;
  logic rx_byte_valid, rx_byte_ready, fifo_mode, rx_data_irq;
  int fail_count = 0, compares = 0;
  int tx_holding_reg[4] = '{int'(TRIG_1), int'(TRIG_4), int'(TRIG_8), QUEUE_DEPTH};
  always #25 ref_clk = ~ref_clk;
  uart_fifo_line_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wr_data(wr_data), .rd_data(rd_data), .test_mode(test_mode), .baud_clock_out(baud_clock_out),
    .tx_shift_serial(tx_shift_serial), .transmitter_empty(transmitter_empty), .serial_out(serial_out),
    .divisor(divisor), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready), .tx_byte(tx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready), .rx_byte(rx_byte), .fifo_mode(fifo_mode),
    .rx_data_irq(rx_data_irq));
  serial_far_end u_far (.ref_clk(ref_clk), .stall(stall), .tx_byte_valid(tx_byte_valid),
    .tx_byte_ready(tx_byte_ready), .tx_byte(tx_byte), .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
    .rx_byte(rx_byte), .baud_clock_out(baud_clock_out), .tx_shift_serial(tx_shift_serial),
    .transmitter_empty(transmitter_empty));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge ref_clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge ref_clk);
    rd_en = 1'b0;
    chk(rd_data, e);
  endtask
  task automatic results;
    $display("Compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    rd(OFS_LINE_CTRL, LINE_CONTROL_RESET);
    rd(OFS_INT_IDENT, {4'h0, IDENT_NONE});
    wr(OFS_LINE_CTRL, 8'h80);
    wr(OFS_DIV_LOW, 8'h34);
    wr(OFS_DIV_HIGH, 8'h12);
    rd(OFS_DIV_HIGH, 8'h12);
    wr(OFS_LINE_CTRL, 8'h00);
    wr(OFS_INT_ENABLE, 8'h01);
    chk(divisor[7:0], 8'h34);
    $display("Done: registers");
    for (int c = 0; c < 4; c++) begin
      wr(OFS_QUEUE_CTRL, {c[1:0], 6'h0b});
      repeat (3) @(negedge ref_clk);
      for (int i = 0; i < tx_holding_reg[c]; i++) begin
        chk(8'(rx_data_irq), 8'h00);
        u_far.push(8'(160 + i));
      end
      chk(8'(rx_data_irq), 8'h01);
      if (c == 0) begin
        rd(OFS_INT_IDENT, {FIFO_STATUS_ON, 2'b00, IDENT_RX_AVAIL});
        rd(OFS_DATA, 8'ha0);
        @(negedge ref_clk);
        chk(8'(rx_data_irq), 8'h00);
      end
    end
    chk(8'(rx_byte_ready), 8'h00);
    $display("Done: trigger");
    wr(OFS_QUEUE_CTRL, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk(8'(rx_data_irq), 8'h00);
    u_far.push(8'h55);
    chk(8'(rx_data_irq), 8'h01);
    wr(OFS_QUEUE_CTRL, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk(8'(rx_data_irq), 8'h00);
    $display("Done: mode");
    stall = 1'b1;
    for (int i = 0; i < 9; i++)
      wr(OFS_DATA, 8'(16 + i));
    stall = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk(8'(u_far.got.size()), 8'h08);
    for (int i = 0; i < 8; i++)
      chk(u_far.got[i], 8'(16 + i));
    stall = 1'b1;
    wr(OFS_DATA, 8'h99);
    wr(OFS_QUEUE_CTRL, 8'h05);
    repeat (3) @(negedge ref_clk);
    chk(8'(tx_byte_valid), 8'h00);
    stall = 1'b0;
    $display("Done: transmit");
    wr(OFS_LINE_CTRL, 8'h40);
    wr(OFS_DATA, 8'h77);
    repeat (3) @(negedge ref_clk);
    chk(8'(serial_out), 8'h00);
    chk(u_far.got[8], 8'h77);
    test_mode = 1'b1;
    wr(OFS_LINE_CTRL, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk(8'(serial_out), 8'h01);
    wr(OFS_LINE_CTRL, 8'h80);
    repeat (2) begin
      @(negedge ref_clk);
      chk(8'(serial_out), 8'(baud_clock_out));
    end
    test_mode = 1'b0;
    $display("Done: line");
    results();
  end
  initial begin
    #200us;
    fail_count++;
    results();
  end
endmodule // test_uart_fifo_and_line_control
